// ---- pkg/phc_pkg.sv ----
// shared types and constants for the ptp/oam header comparator
package phc_pkg;

  // ==========================================================================
  // sizes
  // ==========================================================================
  localparam int NUM_FLOWS = 6;
  localparam int FLOW_IDX_W = 3;
  localparam int KEY_W = 64;

  // ==========================================================================
  // header location, in bytes from the first byte of the frame
  // ==========================================================================
  localparam logic [7:0] ETH_HDR_BYTES = 8'h0E;
  localparam logic [7:0] ACH_BYTES = 8'h04;
  localparam logic [1:0] MAX_VLAN_TAGS = 2'h2;
  localparam logic [2:0] MIN_MPLS_LABELS = 3'h1;
  localparam logic [2:0] MAX_MPLS_LABELS = 3'h4;
  localparam logic [7:0] BYTE_CNT_MAX = 8'hFF;

  // ==========================================================================
  // key lengths and key masks
  // ==========================================================================
  localparam logic [3:0] PTP_KEY_BYTES = 4'h8;
  localparam logic [3:0] OAM_KEY_BYTES = 4'h4;
  localparam logic [63:0] PTP_KEY_MASK = 64'hFFFFFFFF_FFFFFFFF;
  localparam logic [63:0] OAM_KEY_MASK = 64'hFFFFFFFF_00000000;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0] RST_BYTE_CNT = 8'h00;
  localparam logic [7:0] RST_HDR_OFF = 8'h00;
  localparam logic [3:0] RST_KEY_CNT = 4'h0;
  localparam logic [63:0] RST_KEY = 64'h00000000_00000000;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {PHC_PROTO_PTP, PHC_PROTO_ETH_OAM, PHC_PROTO_MPLS_OAM, PHC_PROTO_NONE} phc_proto_e;

  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [7:0] data;
  } phc_beat_s;

  typedef struct packed {
    phc_proto_e proto;
    logic [1:0] vlan_cnt;
    logic [2:0] label_cnt;
    logic [7:0] hdr_offset;
  } phc_desc_s;

  typedef struct packed {
    logic [2:0] cmd;
    logic save_local_time;
    logic [4:0] corr_offset;
  } phc_action_s;

  typedef struct packed {
    logic ena;
    logic [63:0] flow_header_pattern;
    phc_action_s action;
  } phc_flow_s;

  typedef struct packed {
    logic valid;
    logic located;
    logic hit;
    logic [2:0] flow;
    phc_action_s action;
  } phc_result_s;

endpackage

// ---- core/phc_header_comparator.sv ----
// ptp/oam header comparator: last analyzer stage, picks the per-flow action
`timescale 1ns/1ps
// Summary of operation
// - this is the last analyzer stage; its result is the final classification
// - classifies ptp event frames and oam delay-measurement frames alike
// - ptp frames are not validated, the header is only interpreted
// - ptp action decided from the first eight header bytes only
// - key compared to each flow's pattern; matching flow supplies its own action
// - ethernet oam one-way delay, delay request and reply headers are supported
// - ethernet oam not validated; first four header bytes decide the action
// - mpls oam delay pdus of both standards are supported
// - mpls oam pdus not validated; first four header bytes decide the action
// - mpls oam header found behind zero, one or two vlan tags
// - mpls oam header found behind one to four mpls labels
// - each flow holds a 64-bit pattern aligned to the protocol header start
// - one mask shared by all flows; other settings are per flow
module phc_header_comparator (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire phc_pkg::phc_beat_s i_beat,
  input wire phc_pkg::phc_desc_s i_desc,
  input wire phc_pkg::phc_flow_s [phc_pkg::NUM_FLOWS-1:0] i_flow,
  input wire logic [63:0] i_flow_header_mask,
  output phc_pkg::phc_beat_s o_beat,
  output phc_pkg::phc_result_s o_result
);

  // ==========================================================================
  // decoding helpers
  // ==========================================================================
  // {found, offset} of the protocol header for a frame descriptor
  function automatic logic [8:0] locate(input phc_pkg::phc_desc_s d);
    logic ok;
    logic [7:0] off;
    ok = 1'b0;
    off = phc_pkg::RST_HDR_OFF;
    case (d.proto)
      phc_pkg::PHC_PROTO_PTP, phc_pkg::PHC_PROTO_ETH_OAM:
      begin
        ok = 1'b1;
        off = d.hdr_offset;
      end
      phc_pkg::PHC_PROTO_MPLS_OAM:
      begin
        ok = (d.vlan_cnt <= phc_pkg::MAX_VLAN_TAGS) && (d.label_cnt >= phc_pkg::MIN_MPLS_LABELS)
          && (d.label_cnt <= phc_pkg::MAX_MPLS_LABELS);
        off = phc_pkg::ETH_HDR_BYTES + {4'h0, d.vlan_cnt, 2'b00} + {3'h0, d.label_cnt, 2'b00}
          + phc_pkg::ACH_BYTES;
      end
      default:
      begin
        ok = 1'b0;
        off = phc_pkg::RST_HDR_OFF;
      end
    endcase
    return {ok, off};
  endfunction

  // header bytes that decide the action
  function automatic logic [3:0] key_len(input phc_pkg::phc_proto_e p);
    return (p == phc_pkg::PHC_PROTO_PTP) ? phc_pkg::PTP_KEY_BYTES : phc_pkg::OAM_KEY_BYTES;
  endfunction

  function automatic logic flow_match(input logic [63:0] pat, input logic [63:0] key, input logic [63:0] msk);
    return ((pat ^ key) & msk) == 64'h00000000_00000000;
  endfunction

  // ==========================================================================
  // frame tracking state
  // ==========================================================================
  typedef enum logic [1:0] {PHC_IDLE, PHC_CAPT, PHC_EVAL, PHC_DRAIN} phc_state_e;

  phc_state_e state;
  phc_state_e next_state;
  phc_pkg::phc_proto_e proto;
  phc_pkg::phc_proto_e next_proto;
  logic [7:0] hdr_off;
  logic [7:0] next_hdr_off;
  logic [7:0] byte_cnt;
  logic [7:0] next_byte_cnt;
  logic [63:0] key;
  logic [63:0] next_key;
  logic [3:0] key_cnt;
  logic [3:0] next_key_cnt;
  logic eof_seen;
  logic next_eof_seen;
  phc_pkg::phc_result_s result;
  phc_pkg::phc_result_s next_result;
  phc_pkg::phc_beat_s beat;

  logic [8:0] loc;
  logic [7:0] cur_off;
  logic [7:0] cur_cnt;
  logic take;
  logic [63:0] eff_mask;
  logic [phc_pkg::NUM_FLOWS-1:0] hit_vec;
  logic any_hit;
  logic [2:0] sel_flow;
  phc_pkg::phc_action_s sel_action;

  assign loc = locate(i_desc);

  // ==========================================================================
  // flow comparison
  // ==========================================================================
  // oam keys only use the leading four bytes
  assign eff_mask = i_flow_header_mask & ((proto == phc_pkg::PHC_PROTO_PTP) ? phc_pkg::PTP_KEY_MASK
    : phc_pkg::OAM_KEY_MASK);

  for (genvar f = 0; f < phc_pkg::NUM_FLOWS; f++)
  begin : g_flow
    assign hit_vec[f] = i_flow[f].ena && flow_match(i_flow[f].flow_header_pattern, key, eff_mask);
  end

  // lowest-numbered matching flow wins
  always_comb
  begin
    any_hit = 1'b0;
    sel_flow = 3'h0;
    sel_action = '0;
    for (int f = phc_pkg::NUM_FLOWS - 1; f >= 0; f--)
    begin
      if (hit_vec[f])
      begin
        any_hit = 1'b1;
        sel_flow = f[2:0];
        sel_action = i_flow[f].action;
      end
    end
  end

  // ==========================================================================
  // capture of the leading header bytes
  // ==========================================================================
  always_comb
  begin
    next_state = state;
    next_proto = proto;
    next_hdr_off = hdr_off;
    next_byte_cnt = byte_cnt;
    next_key = key;
    next_key_cnt = key_cnt;
    next_eof_seen = eof_seen;
    next_result = '0;
    cur_off = hdr_off;
    cur_cnt = byte_cnt;
    take = 1'b0;
    if (i_beat.valid && i_beat.sof)
    begin
      // a new frame always restarts the stage
      next_proto = i_desc.proto;
      next_hdr_off = loc[7:0];
      next_key = phc_pkg::RST_KEY;
      next_key_cnt = phc_pkg::RST_KEY_CNT;
      next_eof_seen = 1'b0;
      cur_off = loc[7:0];
      cur_cnt = phc_pkg::RST_BYTE_CNT;
      next_state = loc[8] ? PHC_CAPT : PHC_DRAIN;
      if (!loc[8] && i_beat.eof)
      begin
        next_state = PHC_IDLE;
      end
      if (!loc[8])
      begin
        // header not locatable: pass the frame with no action
        next_result.valid = 1'b1;
      end
    end
    if (i_beat.valid)
    begin
      next_byte_cnt = (cur_cnt == phc_pkg::BYTE_CNT_MAX) ? cur_cnt : cur_cnt + 8'h01;
    end
    if (i_beat.valid && (i_beat.sof ? loc[8] : (state == PHC_CAPT)))
    begin
      take = cur_cnt >= cur_off;
      if (take)
      begin
        // no content checks: any byte value is simply taken into the key
        next_key[{~next_key_cnt[2:0], 3'b000} +: 8] = i_beat.data;
        next_key_cnt = next_key_cnt + 4'h1;
        if (next_key_cnt == key_len(next_proto))
        begin
          next_state = PHC_EVAL;
          next_eof_seen = i_beat.eof;
        end
      end
      if (i_beat.eof && next_state != PHC_EVAL)
      begin
        // frame ended inside the header
        next_state = PHC_IDLE;
        next_result.valid = 1'b1;
        next_result.located = 1'b1;
      end
    end
    if (state == PHC_EVAL && !(i_beat.valid && i_beat.sof))
    begin
      next_state = (eof_seen || (i_beat.valid && i_beat.eof)) ? PHC_IDLE : PHC_DRAIN;
    end
    if (state == PHC_EVAL)
    begin
      next_result.valid = 1'b1;
      next_result.located = 1'b1;
      next_result.hit = any_hit;
      next_result.flow = any_hit ? sel_flow : 3'h0;
      next_result.action = any_hit ? sel_action : '0;
    end
    if (state == PHC_DRAIN && i_beat.valid && i_beat.eof && !i_beat.sof)
    begin
      next_state = PHC_IDLE;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      state <= PHC_IDLE;
      proto <= phc_pkg::PHC_PROTO_NONE;
      hdr_off <= phc_pkg::RST_HDR_OFF;
      byte_cnt <= phc_pkg::RST_BYTE_CNT;
      key <= phc_pkg::RST_KEY;
      key_cnt <= phc_pkg::RST_KEY_CNT;
      eof_seen <= 1'b0;
      result <= '0;
      beat <= '0;
    end
    else
    begin
      state <= next_state;
      proto <= next_proto;
      hdr_off <= next_hdr_off;
      byte_cnt <= next_byte_cnt;
      key <= next_key;
      key_cnt <= next_key_cnt;
      eof_seen <= next_eof_seen;
      result <= next_result;
      beat <= i_beat;
    end
  end

  assign o_beat = beat;
  assign o_result = result;

  // ==========================================================================
  // checks
  // ==========================================================================
  frame_passthru_a:
    assert property (@(posedge i_mclk) disable iff (!i_resetn) i_resetn |=> o_beat == $past(i_beat))
    else $error("frame beat not passed through unchanged");

  nohit_noaction_a:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
      o_result.valid && !o_result.hit |-> o_result.action == '0 && o_result.flow == 3'h0)
    else $error("action given without a matching flow");

  eval_result_a:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
      state == PHC_EVAL |=> o_result.valid && o_result.hit == $past(any_hit)
        && o_result.action == $past(sel_action))
    else $error("result does not follow the flow comparison");

  ptp_key_len_a:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
      state == PHC_EVAL && proto == phc_pkg::PHC_PROTO_PTP |-> key_cnt == 4'h8)
    else $error("ptp key is not eight bytes");

  oam_key_len_a:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
      state == PHC_EVAL && proto != phc_pkg::PHC_PROTO_PTP |-> key_cnt == 4'h4 && key[31:0] == 32'h00000000)
    else $error("oam key is not four bytes");

  mpls_offset_a:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
      i_beat.valid && i_beat.sof && i_desc.proto == phc_pkg::PHC_PROTO_MPLS_OAM && i_desc.vlan_cnt == 2'h2
        && i_desc.label_cnt == 3'h4 |=> hdr_off == 8'h2A && state != PHC_DRAIN)
    else $error("mpls header offset wrong behind two tags and four labels");

  mpls_reject_a:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
      i_beat.valid && i_beat.sof && !i_beat.eof && i_desc.proto == phc_pkg::PHC_PROTO_MPLS_OAM
        && i_desc.label_cnt > 3'h4 |=> state == PHC_DRAIN && o_result.valid && !o_result.located)
    else $error("label stack beyond four labels was not rejected");

  mask_match_a:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
      state == PHC_EVAL && i_flow[0].ena && (((i_flow[0].flow_header_pattern ^ key) & eff_mask) == 64'h0)
        |=> o_result.hit && o_result.flow == 3'h0)
    else $error("flow zero matched but was not selected");

  short_frame_a:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
      state == PHC_CAPT && i_beat.valid && !i_beat.sof && i_beat.eof && next_state != PHC_EVAL
        |=> o_result.valid && !o_result.hit ##1 !o_result.valid || $past(i_beat.sof))
    else $error("short frame did not end with a no-action result");

  unlocated_result_a:
    assert property (@(posedge i_mclk) disable iff (!i_resetn)
      i_beat.valid && i_beat.sof && i_desc.proto == phc_pkg::PHC_PROTO_NONE && state != PHC_EVAL
        |=> o_result.valid && !o_result.located && !o_result.hit)
    else $error("frame with no header did not give a no-action result");

endmodule

// ---- tb/phc_upstream_model.sv ----
// upstream analyzer model: streams one frame and its descriptor, byte per beat
`timescale 1ns/1ps
module phc_upstream_model (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_go,
  input wire logic i_slow,
  input wire logic [63:0][7:0] i_frame,
  input wire logic [6:0] i_len,
  input wire phc_pkg::phc_desc_s i_desc,
  output phc_pkg::phc_beat_s o_beat,
  output phc_pkg::phc_desc_s o_desc,
  output logic o_busy
);
  logic [6:0] idx = '0;
  logic [7:0] noise = 8'h00;
  bit send;
  initial
  begin
    o_busy = 1'b0;
    o_beat = '0;
    o_desc = '0;
  end
  // idle data keeps moving and the descriptor is inverted off the first beat so stale values never look valid
  always @(posedge i_mclk)
  begin
    send = i_resetn && o_busy && !(i_slow && $urandom_range(1));
    noise <= noise + 8'h5B;
    o_beat <= send ? {1'b1, idx == 7'h00, idx == i_len - 7'h01, i_frame[idx]} : {3'h0, noise};
    o_desc <= (send && idx == 7'h00) ? i_desc : phc_pkg::phc_desc_s'(~i_desc);
    if (!i_resetn)
    begin
      o_busy <= 1'b0;
    end
    else if (i_go && !o_busy)
    begin
      o_busy <= 1'b1;
      idx <= '0;
    end
    else if (send)
    begin
      idx <= idx + 7'h01;
      o_busy <= idx != i_len - 7'h01;
    end
  end
endmodule

// ---- tb/phc_header_comparator_tb_top.sv ----
// random and corner frame stimulus with self-checking for the header comparator
`timescale 1ns/1ps
module phc_header_comparator_tb_top;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [63:0][7:0] frm = '0;
  logic [6:0] len = 7'h01;
  phc_pkg::phc_desc_s desc = '0;
  phc_pkg::phc_flow_s [phc_pkg::NUM_FLOWS-1:0] flows = '0;
  logic [63:0] mask = '0;
  phc_pkg::phc_beat_s beat, o_beat, prev;
  phc_pkg::phc_desc_s sdesc;
  phc_pkg::phc_result_s o_result, want_res;
  logic busy;
  int failures = 0, samples_checked = 0, cyc = 0, trig_cyc = 0, bidx = 0, tidx = 0, dly = 0, nres = 0;
  bit chk = 1'b0;

  phc_upstream_model src_u (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_go(go), .i_slow(slow), .i_frame(frm),
    .i_len(len), .i_desc(desc), .o_beat(beat), .o_desc(sdesc), .o_busy(busy));
  phc_header_comparator dut_u (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_beat(beat), .i_desc(sdesc),
    .i_flow(flows), .i_flow_header_mask(mask), .o_beat(o_beat), .o_result(o_result));

  always #5 i_mclk = ~i_mclk;

  // ==========================================================================
  // checking and closing
  // ==========================================================================
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // monitor: trigger beat, result timing and content, beat pass-through
  // ==========================================================================
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    prev <= beat;
    if (beat.valid)
    begin
      bidx <= beat.sof ? 1 : bidx + 1;
      if ((beat.sof ? 0 : bidx) == tidx)
      begin
        trig_cyc <= cyc + 1;
      end
    end
  end

  always @(negedge i_mclk)
  begin
    if (chk)
    begin
      check("beat", o_beat, prev);
      if (o_result.valid === 1'b1)
      begin
        nres++;
        check("cycle", cyc, trig_cyc + dly);
        check("located", o_result.located, want_res.located);
        check("hit", o_result.hit, want_res.hit);
        check("flow", o_result.flow, want_res.flow);
        check("action", o_result.action, want_res.action);
      end
    end
  end

  // ==========================================================================
  // expectations
  // ==========================================================================
  function automatic logic [63:0] key_at(logic [63:0][7:0] f, int off, int n);
    logic [63:0] k;
    k = '0;
    for (int i = 0; i < n; i++)
    begin
      k[63-8*i -: 8] = f[off+i];
    end
    return k;
  endfunction

  function automatic int hdr_off(phc_pkg::phc_desc_s d);
    if (d.proto == phc_pkg::PHC_PROTO_NONE)
      return -1;
    if (d.proto != phc_pkg::PHC_PROTO_MPLS_OAM)
      return d.hdr_offset;
    if (d.vlan_cnt > 2 || d.label_cnt < 1 || d.label_cnt > 4)
      return -1;
    return phc_pkg::ETH_HDR_BYTES + 4 * (d.vlan_cnt + d.label_cnt) + phc_pkg::ACH_BYTES;
  endfunction

  // ==========================================================================
  // one frame: build, drive, wait for its single result
  // ==========================================================================
  task automatic run_frame(input int p, input int v, input int l, input bit cut, input bit s);
    logic [63:0][7:0] f;
    phc_pkg::phc_desc_s d;
    phc_pkg::phc_flow_s [phc_pkg::NUM_FLOWS-1:0] fl;
    phc_pkg::phc_result_s e;
    logic [63:0] m, me, key;
    int off, n, ln, n0, k;
    for (int i = 0; i < 64; i++)
      f[i] = 8'($urandom);
    d.proto = phc_pkg::phc_proto_e'(p);
    d.vlan_cnt = 2'(v);
    d.label_cnt = 3'(l);
    d.hdr_offset = 8'($urandom_range(40));
    off = hdr_off(d);
    n = p == 0 ? 8 : 4;
    m = {$urandom, $urandom};
    me = p == 0 ? m : m & phc_pkg::OAM_KEY_MASK;
    key = off < 0 ? 64'h0 : key_at(f, off, n);
    ln = off < 0 ? $urandom_range(64, 1) : cut ? off + $urandom_range(n - 1, 1) : $urandom_range(64, off + n);
    e = '0;
    e.valid = 1'b1;
    e.located = off >= 0;
    for (int i = phc_pkg::NUM_FLOWS - 1; i >= 0; i--)
    begin
      fl[i] = {1'($urandom), $urandom, $urandom, 9'($urandom)};
      if ($urandom_range(1))
        fl[i].flow_header_pattern = key ^ ({$urandom, $urandom} & ~me);
      if (off >= 0 && !cut && fl[i].ena && ((fl[i].flow_header_pattern ^ key) & me) == 64'h0)
      begin
        e.hit = 1'b1;
        e.flow = 3'(i);
        e.action = fl[i].action;
      end
    end
    @(posedge i_mclk);
    frm <= f;
    len <= 7'(ln);
    desc <= d;
    flows <= fl;
    mask <= m;
    want_res <= e;
    tidx <= off < 0 ? 0 : cut ? ln - 1 : off + n - 1;
    dly <= (off >= 0 && !cut) ? 1 : 0;
    slow <= s;
    go <= 1'b1;
    n0 = nres;
    @(posedge i_mclk);
    go <= 1'b0;
    for (k = 0; k < 500 && (busy || nres == n0); k++)
      @(posedge i_mclk);
    if (k == 500)
    begin
      check("wait", 1, 0);
      complete_run();
    end
    else
    begin
      repeat (4) @(posedge i_mclk);
      check("results", nres - n0, 1);
    end
  endtask

  initial
  begin
    void'($urandom(32'h298E));
    repeat (6) @(posedge i_mclk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_mclk);
    chk = 1'b1;
    for (int p = 0; p < 4; p++)
      for (int c = 0; c < 2; c++)
        run_frame(p, 1, 2, c, c);
    $display("protocol corners done");
    for (int v = 0; v < 4; v++)
      for (int l = 0; l < 6; l++)
        run_frame(2, v, l, 1'b0, v[0]);
    $display("tag and label corners done");
    for (int i = 0; i < 150; i++)
      run_frame($urandom_range(3), $urandom_range(3), $urandom_range(5), $urandom_range(3) == 0, $urandom_range(1));
    $display("random frames done");
    complete_run();
  end
endmodule
